// >>> srcm_top.sv
// SYSREF capture monitor with AXI4-Lite register slave
`timescale 1ns/1ps
module srcm_top (
   input  wire logic                      aclk,
   input  wire logic                      aresetn,
   input  wire logic                      sysref_in,
   input  wire logic [3:0]                div_phase,
   input  wire logic [7:0]                margin_in,
   output logic                           sysref_stamp,
   output logic                           irq,
   input  wire logic [srcm_pkg::ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                      s_axi_awvalid,
   output logic                           s_axi_awready,
   input  wire logic [srcm_pkg::DATA_W-1:0] s_axi_wdata,
   input  wire logic [3:0]                s_axi_wstrb,
   input  wire logic                      s_axi_wvalid,
   output logic                           s_axi_wready,
   output logic [1:0]                     s_axi_bresp,
   output logic                           s_axi_bvalid,
   input  wire logic                      s_axi_bready,
   input  wire logic [srcm_pkg::ADDR_W-1:0] s_axi_araddr,
   input  wire logic                      s_axi_arvalid,
   output logic                           s_axi_arready,
   output logic [srcm_pkg::DATA_W-1:0]    s_axi_rdata,
   output logic [1:0]                     s_axi_rresp,
   output logic                           s_axi_rvalid,
   input  wire logic                      s_axi_rready
);
   import srcm_pkg::*;

   srcm_ctrl_s          ctrl_reg;
   logic [3:0]          skip_cfg_reg;
   logic [TSDLY_W-1:0]  tsdly_reg;
   srcm_margin_s        margin_reg;
   logic [3:0]          phase_reg;
   logic [7:0]          count_reg;
   logic [INT_W-1:0]    int_stat_reg;
   logic [INT_W-1:0]    int_mask_reg;
   logic [INT_W-1:0]    int_ev;
   logic [INT_W-1:0]    int_stat_next;
   srcm_state_e         state_reg;
   logic [3:0]          skip_cnt_reg;
   logic                sr_sync;
   logic                sr_prev_reg;
   logic                sr_edge;
   logic                capture;
   logic                mode_on;
   logic [7:0]          margin_sync;
   logic                stamp_pulse;
   logic                aw_got_reg;
   logic                w_got_reg;
   logic [ADDR_W-1:0]   awaddr_reg;
   logic [DATA_W-1:0]   wdata_reg;
   logic                wstrb0_reg;
   logic                wr_fire;
   logic                rd_fire;
   logic [DATA_W-1:0]   rd_value;

   // Address decode shared by read and write paths
   function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
      logic [9:0] i;
      i = a[ADDR_W-1:2];
      addr_hit = (i == IDX_CTRL) || (i == IDX_SKIP) || (i == IDX_TSDLY) ||
                 (i == IDX_MARGIN) || (i == IDX_PHASE) || (i == IDX_COUNT) ||
                 (i == IDX_INT_STAT) || (i == IDX_INT_MASK);
   endfunction : addr_hit

   // Input synchronisers
   srcm_sync #(.W(1)) u_sync_sysref (
      .aclk    (aclk),
      .aresetn (aresetn),
      .d_in    (sysref_in),
      .d_out   (sr_sync)
   );

   srcm_sync #(.W(8)) u_sync_margin (
      .aclk    (aclk),
      .aresetn (aresetn),
      .d_in    (margin_in),
      .d_out   (margin_sync)
   );

   // Timestamp delay line
   srcm_delay_line #(.DEPTH(TSDLY_DEPTH), .SELW(TSDLY_W)) u_delay (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .pulse_in  (capture),
      .delay     (tsdly_reg),
      .pulse_out (stamp_pulse)
   );

   assign sysref_stamp = stamp_pulse;

   // Transition detect
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sr_prev_reg <= 1'b0;
      end else begin
         sr_prev_reg <= sr_sync;
      end
   end

   assign sr_edge = sr_sync & ~sr_prev_reg;
   assign mode_on = (ctrl_reg.mode == MODE_CONT) || (ctrl_reg.mode == MODE_NSHOT);
   assign capture = sr_edge &&
                    ((state_reg == ST_CONT) || ((state_reg == ST_SKIP) && (skip_cnt_reg == 4'h0)));

   // Capture mode sequencing
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_reg    <= ST_OFF;
         skip_cnt_reg <= SKIP_RST;
      end else begin
         case (state_reg)
            ST_OFF: begin
               if (ctrl_reg.mode == MODE_CONT) begin
                  state_reg <= ST_CONT;
               end else if (ctrl_reg.mode == MODE_NSHOT) begin
                  state_reg    <= ST_SKIP;
                  skip_cnt_reg <= skip_cfg_reg;
               end
            end
            ST_CONT: begin
               if (!mode_on) begin
                  state_reg <= ST_OFF;
               end else if (ctrl_reg.mode == MODE_NSHOT) begin
                  state_reg <= ST_DONE;
               end
            end
            ST_SKIP: begin
               if (ctrl_reg.mode == MODE_CONT) begin
                  state_reg <= ST_CONT;
               end else if (!mode_on) begin
                  state_reg <= ST_OFF;
               end else if (sr_edge) begin
                  if (skip_cnt_reg == 4'h0) begin
                     state_reg <= ST_DONE;
                  end else begin
                     skip_cnt_reg <= skip_cnt_reg - 4'h1;
                  end
               end
            end
            ST_DONE: begin
               if (ctrl_reg.mode == MODE_CONT) begin
                  state_reg <= ST_CONT;
               end else if (!mode_on) begin
                  state_reg <= ST_OFF;
               end
            end
            default: begin
               state_reg <= ST_OFF;
            end
         endcase
      end
   end

   // Captured-event counter
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         count_reg <= COUNT_RST;
      end else if (ctrl_reg.flag_rst) begin
         count_reg <= COUNT_RST;
      end else if (capture) begin
         count_reg <= count_reg + 8'h01;
      end
   end

   // Margin status snapshot
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         margin_reg <= MARGIN_RST;
      end else if (ctrl_reg.flag_rst) begin
         margin_reg <= MARGIN_RST;
      end else if (capture) begin
         margin_reg <= margin_sync;
      end
   end

   // Divider phase snapshot
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         phase_reg <= PHASE_RST;
      end else if (capture) begin
         phase_reg <= div_phase;
      end
   end

   // Interrupt status, set wins over read clear
   assign int_ev[INT_CAPT_BIT]  = capture;
   assign int_ev[INT_STAMP_BIT] = stamp_pulse;
   assign int_ev[INT_WRAP_BIT]  = capture && !ctrl_reg.flag_rst && (count_reg == COUNT_MAX);

   always_comb begin
      int_stat_next = int_stat_reg;
      if (rd_fire && (s_axi_araddr[ADDR_W-1:2] == IDX_INT_STAT)) begin
         int_stat_next = '0;
      end
      int_stat_next = int_stat_next | int_ev;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         int_stat_reg <= '0;
         irq          <= 1'b0;
      end else begin
         int_stat_reg <= int_stat_next;
         irq          <= |(int_stat_next & int_mask_reg);
      end
   end

   // Write address and data channels, taken in either order
   assign wr_fire = aw_got_reg && w_got_reg && !s_axi_bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         aw_got_reg    <= 1'b0;
         awaddr_reg    <= '0;
      end else begin
         s_axi_awready <= !s_axi_awready && s_axi_awvalid && !aw_got_reg && !s_axi_bvalid;
         if (s_axi_awready && s_axi_awvalid) begin
            aw_got_reg <= 1'b1;
            awaddr_reg <= s_axi_awaddr;
         end else if (wr_fire) begin
            aw_got_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_wready <= 1'b0;
         w_got_reg    <= 1'b0;
         wdata_reg    <= '0;
         wstrb0_reg   <= 1'b0;
      end else begin
         s_axi_wready <= !s_axi_wready && s_axi_wvalid && !w_got_reg && !s_axi_bvalid;
         if (s_axi_wready && s_axi_wvalid) begin
            w_got_reg  <= 1'b1;
            wdata_reg  <= s_axi_wdata;
            wstrb0_reg <= s_axi_wstrb[0];
         end else if (wr_fire) begin
            w_got_reg <= 1'b0;
         end
      end
   end

   // Write response
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= addr_hit(awaddr_reg) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Writable registers, low byte lane only
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_reg     <= '{flag_rst: FRST_RST, mode: MODE_RST};
         skip_cfg_reg <= SKIP_RST;
         tsdly_reg    <= TSDLY_RST;
         int_mask_reg <= INT_MASK_RST;
      end else if (wr_fire && wstrb0_reg) begin
         case (awaddr_reg[ADDR_W-1:2])
            IDX_CTRL: begin
               ctrl_reg.flag_rst <= wdata_reg[CTRL_FRST_BIT];
               ctrl_reg.mode     <= wdata_reg[CTRL_MODE_LSB +: 2];
            end
            IDX_SKIP:     skip_cfg_reg <= wdata_reg[3:0];
            IDX_TSDLY:    tsdly_reg    <= wdata_reg[TSDLY_W-1:0];
            IDX_INT_MASK: int_mask_reg <= wdata_reg[INT_W-1:0];
            default: begin
            end
         endcase
      end
   end

   // Read channel
   assign rd_fire = s_axi_arready && s_axi_arvalid;

   always_comb begin
      rd_value = '0;
      case (s_axi_araddr[ADDR_W-1:2])
         IDX_CTRL: begin
            rd_value[CTRL_FRST_BIT]       = ctrl_reg.flag_rst;
            rd_value[CTRL_MODE_LSB +: 2]  = ctrl_reg.mode;
         end
         IDX_SKIP:     rd_value[3:0]         = skip_cfg_reg;
         IDX_TSDLY:    rd_value[TSDLY_W-1:0] = tsdly_reg;
         IDX_MARGIN:   rd_value[7:0]         = margin_reg;
         IDX_PHASE:    rd_value[3:0]         = phase_reg;
         IDX_COUNT:    rd_value[7:0]         = count_reg;
         IDX_INT_STAT: rd_value[INT_W-1:0]   = int_stat_reg;
         IDX_INT_MASK: rd_value[INT_W-1:0]   = int_mask_reg;
         default:      rd_value              = '0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_arready && s_axi_arvalid && !s_axi_rvalid;
         if (rd_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_value;
            s_axi_rresp  <= addr_hit(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // Checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_skip_act_zero: assert property (
      (state_reg == ST_SKIP) && sr_edge && (skip_cnt_reg == 4'h0) |-> capture)
      else $error("Counted mode missed the transition after skipping");

   a_skip_ignore_one: assert property (
      (state_reg == ST_SKIP) && sr_edge && (skip_cnt_reg != 4'h0) && (ctrl_reg.mode == MODE_NSHOT)
      |-> !capture ##1 (skip_cnt_reg == $past(skip_cnt_reg) - 4'h1))
      else $error("Skipped transition not counted down");

   a_stamp_reset_dly: assert property (
      capture && (tsdly_reg == 7'h40) ##1 $stable(tsdly_reg) |-> ##64 sysref_stamp)
      else $error("Timestamp not issued 65 cycles after capture");

   a_stamp_zero_dly: assert property (
      capture && (tsdly_reg == 7'h00) |=> sysref_stamp)
      else $error("Zero delay timestamp late");

   a_margin_capture: assert property (
      capture && !ctrl_reg.flag_rst |=> (margin_reg == $past(margin_sync)))
      else $error("Margin status not taken at capture");

   a_phase_capture: assert property (
      capture |=> (phase_reg == $past(div_phase)))
      else $error("Divider phase not taken at capture");

   a_count_step: assert property (
      !ctrl_reg.flag_rst ##0 capture |=> (count_reg == $past(count_reg) + 8'h01))
      else $error("Event counter did not step by one");

   a_count_wrap: assert property (
      capture && !ctrl_reg.flag_rst && (count_reg == 8'hFF) |=> (count_reg == 8'h00) && int_stat_reg[INT_WRAP_BIT])
      else $error("Event counter did not wrap");

   a_flag_clear: assert property (
      ctrl_reg.flag_rst |=> (count_reg == 8'h00) && (margin_reg == 8'h00))
      else $error("Flags not held clear under flag reset");

   a_restart_load: assert property (
      (state_reg == ST_OFF) && (ctrl_reg.mode == MODE_NSHOT)
      |=> (state_reg == ST_SKIP) && (skip_cnt_reg == $past(skip_cfg_reg)))
      else $error("Counted mode did not restart skip count");

   a_disable_off: assert property (
      !mode_on |=> (state_reg == ST_OFF))
      else $error("Disabled mode left sequencer running");

   c_cont_capture:  cover property ((state_reg == ST_CONT) && capture);
   c_nshot_skipped: cover property ((state_reg == ST_SKIP) && capture && (skip_cfg_reg != 4'h0));
   c_count_wrap:    cover property (int_ev[INT_WRAP_BIT]);
   c_irq_raised:    cover property ($rose(irq));
endmodule : srcm_top

// >>> srcm_pkg.sv
// Package of constants and types for the SYSREF capture monitor
// Operation
// - Four-bit ignore count skips that many leading SYSREF transitions; zero acts on next.
// - Timestamp delayed by programmable 0 to 127 sample clocks; field resets to 0x40.
// - Read-only status byte: hold margin bits 7:4, setup margin bits 3:0, reset zero.
// - Divider phase at capture kept as four-bit code in half-cycle steps.
// - Read-only eight-bit counter increments once per captured SYSREF event.
// - Counter cleared while flag-reset bit set; wraps to zero after 255.
// - Flag-reset bit held high keeps setup and hold flags cleared.
package srcm_pkg;
   localparam int          ADDR_W        = 12;
   localparam int          DATA_W        = 32;
   localparam logic [9:0]  IDX_CTRL      = 10'h120;
   localparam logic [9:0]  IDX_SKIP      = 10'h121;
   localparam logic [9:0]  IDX_TSDLY     = 10'h123;
   localparam logic [9:0]  IDX_MARGIN    = 10'h128;
   localparam logic [9:0]  IDX_PHASE     = 10'h129;
   localparam logic [9:0]  IDX_COUNT     = 10'h12A;
   localparam logic [9:0]  IDX_INT_STAT  = 10'h130;
   localparam logic [9:0]  IDX_INT_MASK  = 10'h131;
   localparam int          CTRL_FRST_BIT = 6;
   localparam int          CTRL_MODE_LSB = 1;
   localparam logic [1:0]  MODE_OFF      = 2'h0;
   localparam logic [1:0]  MODE_CONT     = 2'h1;
   localparam logic [1:0]  MODE_NSHOT    = 2'h2;
   localparam logic [1:0]  MODE_RST      = 2'h0;
   localparam logic        FRST_RST      = 1'h0;
   localparam logic [3:0]  SKIP_RST      = 4'h0;
   localparam int          TSDLY_W       = 7;
   localparam int          TSDLY_DEPTH   = 128;
   localparam logic [6:0]  TSDLY_RST     = 7'h40;
   localparam logic [7:0]  MARGIN_RST    = 8'h00;
   localparam logic [3:0]  PHASE_RST     = 4'h0;
   localparam logic [7:0]  COUNT_RST     = 8'h00;
   localparam logic [7:0]  COUNT_MAX     = 8'hFF;
   localparam int          INT_W         = 3;
   localparam int          INT_CAPT_BIT  = 0;
   localparam int          INT_STAMP_BIT = 1;
   localparam int          INT_WRAP_BIT  = 2;
   localparam logic [2:0]  INT_MASK_RST  = 3'h0;
   localparam logic [1:0]  RESP_OKAY     = 2'h0;
   localparam logic [1:0]  RESP_SLVERR   = 2'h2;

   typedef struct packed {
      logic [3:0] hold;
      logic [3:0] setup;
   } srcm_margin_s;

   typedef struct packed {
      logic       flag_rst;
      logic [1:0] mode;
   } srcm_ctrl_s;

   typedef enum logic [1:0] {ST_OFF, ST_CONT, ST_SKIP, ST_DONE} srcm_state_e;
endpackage : srcm_pkg

// >>> srcm_sync.sv
// Two-stage synchroniser for signals from outside the clock domain
`timescale 1ns/1ps
module srcm_sync #(
   parameter int W = 1
) (
   input  wire logic         aclk,
   input  wire logic         aresetn,
   input  wire logic [W-1:0] d_in,
   output logic      [W-1:0] d_out
);
   logic [W-1:0] meta_reg;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta_reg <= '0;
         d_out    <= '0;
      end else begin
         meta_reg <= d_in;
         d_out    <= meta_reg;
      end
   end
endmodule : srcm_sync

// >>> srcm_delay_line.sv
// Programmable pulse delay line in sample clock cycles
`timescale 1ns/1ps
module srcm_delay_line #(
   parameter int DEPTH = 128,
   parameter int SELW  = 7
) (
   input  wire logic            aclk,
   input  wire logic            aresetn,
   input  wire logic            pulse_in,
   input  wire logic [SELW-1:0] delay,
   output logic                 pulse_out
);
   logic [DEPTH-1:0] line_reg;

   // Tap 0 is the input itself, so the output lags by delay plus one
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         line_reg  <= '0;
         pulse_out <= 1'b0;
      end else begin
         line_reg  <= {line_reg[DEPTH-2:0], pulse_in};
         pulse_out <= (delay == '0) ? pulse_in : line_reg[delay - 1'b1];
      end
   end
endmodule : srcm_delay_line

// >>> srcm_ref_src.sv
// SYSREF source model: reference pulses, divider phase and margin levels
`timescale 1ns/1ps
module srcm_ref_src (
   input  wire logic       aclk,
   output logic            sysref_in,
   output logic [3:0]      div_phase,
   output logic [7:0]      margin_in
);
   initial begin
      sysref_in = 1'b0;
      div_phase = 4'h0;
      margin_in = 8'h00;
   end

   // Levels settle well before the rise, then a low gap follows it
   task automatic pulse(input logic [3:0] ph, input logic [7:0] mg, input int hi);
      @(posedge aclk);
      div_phase <= ph;
      margin_in <= mg;
      repeat (4) @(posedge aclk);
      sysref_in <= 1'b1;
      repeat (hi) @(posedge aclk);
      sysref_in <= 1'b0;
      repeat (4) @(posedge aclk);
   endtask : pulse
endmodule : srcm_ref_src

// >>> testbench.sv
// Self-checking bench for the SYSREF capture monitor
`timescale 1ns/1ps
module testbench;
   import srcm_pkg::*;
   logic              aclk, aresetn, sysref_in, sysref_stamp, irq, prev;
   logic [3:0]        div_phase, wstrb, ph_e;
   logic [7:0]        margin_in, mg_e;
   logic [ADDR_W-1:0] awaddr, araddr;
   logic              awvalid, awready, wvalid, wready, bvalid, bready;
   logic              arvalid, arready, rvalid, rready;
   logic [DATA_W-1:0] wdata, rdata, rd;
   logic [1:0]        bresp, rresp, rs;
   logic [15:0]       lf;
   int                fails, total_checks, lat, stamps, age, exp_cnt, d, n, i, s0;
   int                sk[4] = '{0, 1, 15, 1};

   srcm_top uut (.aclk(aclk), .aresetn(aresetn), .sysref_in(sysref_in), .div_phase(div_phase),
      .margin_in(margin_in), .sysref_stamp(sysref_stamp), .irq(irq),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

   srcm_ref_src src (.aclk(aclk), .sysref_in(sysref_in), .div_phase(div_phase), .margin_in(margin_in));

   initial begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end

   // Cycles from each SYSREF rise to the stamp, and stamps seen
   always @(posedge aclk) begin
      prev <= sysref_in;
      age  <= (sysref_in && !prev) ? 1 : age + 1;
      if (sysref_stamp === 1'b1) begin
         lat    <= age;
         stamps <= stamps + 1;
      end
   end

   function automatic logic [15:0] lfsr(input logic [15:0] x);
      return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction : lfsr

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : wrap_up

   task automatic check(input string name, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         fails++;
         $display("BAD %s expected %h seen %h", name, e, g);
      end
   endtask : check

   task automatic chk_irq(input string name, input logic e);
      check(name, {31'h0, e}, {31'h0, irq});
   endtask : chk_irq

   task automatic tmo();
      fails++;
      $display("BAD handshake expected answer seen none");
      wrap_up();
   endtask : tmo

   task automatic axi_wr(input logic [9:0] idx, input logic [31:0] dat, output logic [1:0] resp);
      int k;
      @(posedge aclk);
      awaddr  <= {idx, 2'b00};
      wdata   <= dat;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      for (k = 0; k < 100; k++) begin
         @(posedge aclk);
         if (awvalid && awready === 1'b1)
            awvalid <= 1'b0;
         if (wvalid && wready === 1'b1)
            wvalid <= 1'b0;
         if (bvalid === 1'b1) begin
            resp = bresp;
            bready <= 1'b0;
            return;
         end
      end
      tmo();
   endtask : axi_wr

   task automatic axi_rd(input logic [9:0] idx, output logic [31:0] dat, output logic [1:0] resp);
      int k;
      @(posedge aclk);
      araddr  <= {idx, 2'b00};
      arvalid <= 1'b1;
      rready  <= 1'b1;
      for (k = 0; k < 100; k++) begin
         @(posedge aclk);
         if (arvalid && arready === 1'b1)
            arvalid <= 1'b0;
         if (rvalid === 1'b1) begin
            dat = rdata;
            resp = rresp;
            rready <= 1'b0;
            return;
         end
      end
      tmo();
   endtask : axi_rd

   task automatic wr(input logic [9:0] idx, input logic [31:0] dat);
      axi_wr(idx, dat, rs);
      check("bresp", {30'h0, RESP_OKAY}, {30'h0, rs});
   endtask : wr

   task automatic rd_chk(input logic [9:0] idx, input logic [31:0] e, input string name);
      axi_rd(idx, rd, rs);
      check("rresp", {30'h0, RESP_OKAY}, {30'h0, rs});
      check(name, e, rd);
   endtask : rd_chk

   // Counter is read with the mode disabled, then the given control word is written back unless it is zero
   task automatic cnt_chk(input logic [31:0] restore);
      wr(IDX_CTRL, 32'h0);
      rd_chk(IDX_COUNT, exp_cnt, "count");
      if (restore != 0)
         wr(IDX_CTRL, restore);
   endtask : cnt_chk

   task automatic pul(input bit cap);
      lf = lfsr(lf);
      src.pulse(lf[3:0], lf[11:4], 1 + int'(lf[13:12]));
      if (cap) begin
         exp_cnt = (exp_cnt + 1) % 256;
         ph_e = lf[3:0];
         mg_e = lf[11:4];
      end
   endtask : pul

   initial begin
      repeat (100000) @(posedge aclk);
      tmo();
   end

   initial begin
      aresetn = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      awaddr = '0;
      araddr = '0;
      wdata = '0;
      wstrb = 4'hF;
      lf = 16'h0045;
      {fails, total_checks, stamps, age, exp_cnt, lat} = '0;
      prev = 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      rd_chk(IDX_SKIP, {28'h0, SKIP_RST}, "skip reset");
      rd_chk(IDX_TSDLY, {25'h0, TSDLY_RST}, "delay reset");
      rd_chk(IDX_MARGIN, {24'h0, MARGIN_RST}, "margin reset");
      rd_chk(IDX_PHASE, {28'h0, PHASE_RST}, "phase reset");
      rd_chk(IDX_COUNT, {24'h0, COUNT_RST}, "count reset");
      axi_rd(10'h000, rd, rs);
      check("unmapped rresp", {30'h0, RESP_SLVERR}, {30'h0, rs});
      check("unmapped rdata", 32'h0, rd);
      axi_wr(10'h000, 32'hFF, rs);
      check("unmapped bresp", {30'h0, RESP_SLVERR}, {30'h0, rs});
      wr(IDX_MARGIN, 32'hFF);
      rd_chk(IDX_MARGIN, 32'h0, "margin read only");
      // Low byte lane off: nothing is stored
      wstrb <= 4'hE;
      wr(IDX_SKIP, 32'hF);
      wstrb <= 4'hF;
      rd_chk(IDX_SKIP, {28'h0, SKIP_RST}, "skip strobe");
      // Timestamp delay, capture snapshots and interrupts
      wr(IDX_INT_MASK, 32'h3);
      wr(IDX_CTRL, 32'h2);
      for (n = 0; n < 4; n++) begin
         d = (n == 0) ? 0 : (n == 1) ? 127 : (n == 2) ? 64 : int'(lf[6:0]);
         wr(IDX_TSDLY, d);
         pul(1'b1);
         repeat (140) @(posedge aclk);
         // Two sync stages, a combinational edge detect adding no cycle, then delay plus the output register
         check("stamp latency", 3 + d, lat);
         chk_irq("irq raised", 1'b1);
         rd_chk(IDX_INT_STAT, 32'h3, "int status");
         repeat (2) @(posedge aclk);
         chk_irq("irq cleared", 1'b0);
         rd_chk(IDX_PHASE, {28'h0, ph_e}, "phase");
         rd_chk(IDX_MARGIN, {24'h0, mg_e}, "margin");
         cnt_chk(32'h2);
      end
      // Counted-pulse mode with skip counts, re-entered from disabled
      wr(IDX_TSDLY, 32'h0);
      for (n = 0; n < 4; n++) begin
         wr(IDX_CTRL, 32'h0);
         wr(IDX_SKIP, sk[n]);
         rd_chk(IDX_SKIP, sk[n], "skip");
         wr(IDX_CTRL, 32'h4);
         s0 = stamps;
         for (i = 0; i < sk[n] + 3; i++)
            pul(i == sk[n]);
         repeat (10) @(posedge aclk);
         check("counted stamps", s0 + 1, stamps);
         cnt_chk(32'h0);
      end
      // Continuous mode ignores the skip count; disabled ignores pulses
      wr(IDX_CTRL, 32'h2);
      s0 = stamps;
      pul(1'b1);
      pul(1'b1);
      repeat (10) @(posedge aclk);
      check("continuous stamps", s0 + 2, stamps);
      cnt_chk(32'h0);
      pul(1'b0);
      cnt_chk(32'h0);
      // Mode code 11 also counts as disabled
      wr(IDX_CTRL, 32'h6);
      pul(1'b0);
      cnt_chk(32'h0);
      // Flag reset holds counter and margin cleared
      wr(IDX_CTRL, 32'h42);
      pul(1'b0);
      exp_cnt = 0;
      rd_chk(IDX_MARGIN, 32'h0, "margin flag reset");
      cnt_chk(32'h0);
      // Counter wrap with masked then unmasked interrupt
      wr(IDX_INT_MASK, 32'h0);
      rd_chk(IDX_INT_STAT, 32'h3, "flag status");
      wr(IDX_CTRL, 32'h2);
      for (i = 0; i < 256; i++)
         pul(1'b1);
      repeat (10) @(posedge aclk);
      chk_irq("irq masked", 1'b0);
      wr(IDX_INT_MASK, 32'h4);
      repeat (2) @(posedge aclk);
      chk_irq("irq wrap", 1'b1);
      rd_chk(IDX_INT_STAT, 32'h7, "wrap status");
      cnt_chk(32'h0);
      rd_chk(IDX_MARGIN, {24'h0, mg_e}, "margin after flag");
      wrap_up();
   end
endmodule : testbench
